// *** include/synth_div_params.svh ***
// named constants for the synthesizer 0 output C/D post-divider block
`ifndef SYNTH_DIV_PARAMS_SVH
`define SYNTH_DIV_PARAMS_SVH

// register byte addresses, most significant byte at the lowest address
`define ADDR_C_BASE 8'h86
`define ADDR_D_BASE 8'h89
`define ADDR_BYTES 8'h03
`define DIV_RESET_VALUE 24'h000040

// field layout of a divider word
`define MODE_MSB 23
`define MODE_LSB 20
`define FRAME_CODE 4'hF
`define TYPE_BIT 19
`define POL_BIT 18
`define SEL_MSB 17
`define SEL_LSB 16
`define PERIOD_MSB 15
`define PERIOD_LSB 0

// related clock select codes
`define SEL_A 2'h0
`define SEL_B 2'h1
`define SEL_C 2'h2
`define SEL_D 2'h3

// smallest ratio and period the counters can realise
`define MIN_RATIO 24'h000002
`define MIN_PERIOD 16'h0001
`define ZERO_BYTE 8'h00

`endif

// *** include/synth_div_pkg.sv ***
// types shared by the post-divider design files
package synth_div_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [23:0] divider_word_t;
  typedef logic [15:0] frame_count_t;
endpackage

// *** design/clock_ratio_divider.sv ***
// integer clock divider with near 50% duty cycle
`timescale 1ns/1ps
`include "synth_div_params.svh"

module clock_ratio_divider (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable,
  input wire synth_div_pkg::divider_word_t ratio,
  output logic clk_out
);
  import synth_div_pkg::*;

  divider_word_t eff_ratio;
  divider_word_t high_len;
  divider_word_t cnt_reg;
  divider_word_t cnt_next;
  logic [24:0] sum_tmp;

  ////////////////////////////////////////////////////////////////////////
  // ratios below two cannot be made from whole source cycles
  always_comb begin
    eff_ratio = (ratio < `MIN_RATIO) ? `MIN_RATIO : ratio;
    // odd ratios keep the extra cycle high, so small odd ratios skew
    sum_tmp = {1'b0, eff_ratio} + 25'h0000001;
    high_len = sum_tmp[24:1];
    if (!enable || cnt_reg >= eff_ratio - `MIN_RATIO + 24'h000001) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source cycle counter, one wrap per output period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // high for the first half of the period, low for the rest
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= enable && (cnt_reg < high_len);
    end
  end
endmodule

// *** design/synth_post_divider_frame_pulse.sv ***
// synthesizer 0 output C and D post-dividers with frame pulse mode
//
// Behaviour
// - top nibble 1111 selects frame pulse output
// - otherwise whole word divides source, near 50% duty
// - low sixteen bits set pulse spacing
// - two-bit select picks sibling related clock
// - pulse lasts one related clock period
// - bit 18 inverts pulse polarity
// - bit 19 chooses centred or edge-aligned boundary
// - duty within 45-55% except small odd ratios
`timescale 1ns/1ps
`include "synth_div_params.svh"

module synth_post_divider_frame_pulse (
  input wire logic mclk,
  input wire logic nrst,
  input wire synth_div_pkg::reg_byte_t reg_addr,
  input wire synth_div_pkg::reg_byte_t reg_wdata,
  input wire logic reg_wr,
  output synth_div_pkg::reg_byte_t reg_rdata,
  input wire logic related_a,
  input wire logic related_b,
  output logic output_c_ratio,
  output logic output_d_ratio
);
  import synth_div_pkg::*;

  localparam int CHANNELS = 2;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte offset of an address inside a three-byte register, or 3 if out
  function automatic logic [1:0] lane_of(input reg_byte_t addr,
                                          input reg_byte_t base);
    reg_byte_t diff;
    diff = addr - base;
    if (addr >= base && diff < `ADDR_BYTES) begin
      lane_of = diff[1:0];
    end else begin
      lane_of = 2'h3;
    end
  endfunction

  // byte of a word by lane, most significant at lane 0
  function automatic reg_byte_t word_byte(input divider_word_t w,
                                          input logic [1:0] lane);
    case (lane)
      2'h0: word_byte = w[23:16];
      2'h1: word_byte = w[15:8];
      2'h2: word_byte = w[7:0];
      default: word_byte = `ZERO_BYTE;
    endcase
  endfunction

  // new word after a byte write into one lane
  function automatic divider_word_t word_write(input divider_word_t w,
                                               input logic [1:0] lane,
                                               input reg_byte_t d);
    divider_word_t r;
    r = w;
    case (lane)
      2'h0: r[23:16] = d;
      2'h1: r[15:8] = d;
      2'h2: r[7:0] = d;
      default: r = w;
    endcase
    word_write = r;
  endfunction

  // frame pulse mode is flagged by the top nibble
  function automatic logic frame_mode(input divider_word_t w);
    frame_mode = (w[`MODE_MSB:`MODE_LSB] == `FRAME_CODE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file

  divider_word_t div_reg [CHANNELS];
  logic [1:0] lane_c;
  logic [1:0] lane_d;
  logic [1:0] lane [CHANNELS];

  assign lane_c = lane_of(reg_addr, `ADDR_C_BASE);
  assign lane_d = lane_of(reg_addr, `ADDR_D_BASE);
  assign lane[0] = lane_c;
  assign lane[1] = lane_d;

  // byte writes land at once; a multi-byte update passes through
  // intermediate ratios, so software should write the mode byte last
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_reg[0] <= `DIV_RESET_VALUE;
      div_reg[1] <= `DIV_RESET_VALUE;
    end else if (reg_wr) begin
      div_reg[0] <= word_write(div_reg[0], lane_c, reg_wdata);
      div_reg[1] <= word_write(div_reg[1], lane_d, reg_wdata);
    end
  end

  // registered read, unmapped addresses answer zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `ZERO_BYTE;
    end else if (lane_c != 2'h3) begin
      reg_rdata <= word_byte(div_reg[0], lane_c);
    end else if (lane_d != 2'h3) begin
      reg_rdata <= word_byte(div_reg[1], lane_d);
    end else begin
      reg_rdata <= `ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel divider and frame pulse generator

  logic out_bit [CHANNELS];

  assign output_c_ratio = out_bit[0];
  assign output_d_ratio = out_bit[1];

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      localparam logic [1:0] OWN_SEL = (gi == 0) ? `SEL_C : `SEL_D;

      logic is_frame;
      logic sel_ok;
      logic [1:0] sel;
      logic rel_cur;
      logic rel_prev_reg;
      logic rise;
      logic fall;
      logic edge_hit;
      logic last;
      frame_count_t period;
      frame_count_t count_reg;
      logic pulse_reg;
      logic div_clk;

      assign is_frame = frame_mode(div_reg[gi]);
      assign sel = div_reg[gi][`SEL_MSB:`SEL_LSB];
      // a self-selected related clock is held idle
      assign sel_ok = is_frame && (sel != OWN_SEL);

      // sibling mux; the C output feeds D through its own flip-flop
      always_comb begin
        case (sel)
          `SEL_A: rel_cur = related_a;
          `SEL_B: rel_cur = related_b;
          `SEL_C: rel_cur = out_bit[0];
          `SEL_D: rel_cur = out_bit[1];
          default: rel_cur = 1'b0;
        endcase
      end

      // related clocks come from synchronous siblings, no synchroniser
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          rel_prev_reg <= 1'b0;
        end else begin
          rel_prev_reg <= rel_cur;
        end
      end

      assign rise = rel_cur && !rel_prev_reg;
      assign fall = !rel_cur && rel_prev_reg;
      // a zero period is taken as one, which holds the pulse asserted
      assign period = (div_reg[gi][`PERIOD_MSB:`PERIOD_LSB] < `MIN_PERIOD)
                      ? `MIN_PERIOD
                      : div_reg[gi][`PERIOD_MSB:`PERIOD_LSB];
      assign last = (count_reg >= period - `MIN_PERIOD);
      // edge-aligned pulses move on rising edges, centred on falling
      assign edge_hit = div_reg[gi][`TYPE_BIT] ? rise : fall;

      // related rising edge counter, wraps once per frame
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          count_reg <= '0;
        end else if (!sel_ok) begin
          count_reg <= '0;
        end else if (rise) begin
          count_reg <= last ? frame_count_t'(0)
                            : count_reg + `MIN_PERIOD;
        end
      end

      // centred type starts half a related period before the boundary
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          pulse_reg <= 1'b0;
        end else if (!sel_ok) begin
          pulse_reg <= 1'b0;
        end else if (edge_hit) begin
          pulse_reg <= last;
        end
      end

      clock_ratio_divider u_div (
        .mclk(mclk),
        .nrst(nrst),
        .enable(!is_frame),
        .ratio(div_reg[gi]),
        .clk_out(div_clk)
      );

      // output flop: divided clock or frame pulse with polarity
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          out_bit[gi] <= 1'b0;
        end else if (is_frame) begin
          out_bit[gi] <= pulse_reg ^ div_reg[gi][`POL_BIT];
        end else begin
          out_bit[gi] <= div_clk;
        end
      end
    end
  endgenerate
endmodule

// *** tb/sibling_divs.sv ***
// sibling divider A and B outputs feeding the related clock inputs
`timescale 1ns/1ps
module sibling_divs (
  input wire logic mclk,
  input wire logic nrst,
  output logic related_a,
  output logic related_b
);
  logic [3:0] ph_reg;
  // a is mclk/4, b is mclk/6; one counter keeps their phases fixed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_reg <= 4'h0;
    end else begin
      ph_reg <= (ph_reg == 4'hB) ? 4'h0 : ph_reg + 4'h1;
    end
  end
  assign related_a = ph_reg[1];
  assign related_b = (ph_reg % 4'h6) > 4'h2;
endmodule

// *** tb/div_checker.sv ***
// assertion checker for the output C/D post-divider ports
`timescale 1ns/1ps
module div_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire synth_div_pkg::reg_byte_t reg_addr,
  input wire synth_div_pkg::reg_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire synth_div_pkg::reg_byte_t reg_rdata,
  input wire logic related_a,
  input wire logic related_b,
  input wire logic output_c_ratio,
  input wire logic output_d_ratio
);
  import synth_div_pkg::*;
  divider_word_t c_reg, d_reg, c_gap, d_gap;
  logic [1:0] c_n, d_n;
  logic d_on, fa;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // pulse level with polarity removed; fa marks settled frame mode on a
  assign d_on = output_d_ratio ^ d_reg[18];
  assign fa = d_reg[23:20] == 4'hF && d_reg[17:16] == 2'h0 && d_n == 2'h3;
  // shadow words, most significant byte at the base address
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      c_reg <= 24'h000040;
      d_reg <= 24'h000040;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h86: c_reg[23:16] <= reg_wdata;
        8'h87: c_reg[15:8] <= reg_wdata;
        8'h88: c_reg[7:0] <= reg_wdata;
        8'h89: d_reg[23:16] <= reg_wdata;
        8'h8A: d_reg[15:8] <= reg_wdata;
        8'h8B: d_reg[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end
  // gaps between starts; start counts restart on any write so the
  // settling period after a change is never judged
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      c_gap <= 24'h000000;
      d_gap <= 24'h000000;
      c_n <= 2'h0;
      d_n <= 2'h0;
    end else begin
      c_gap <= $rose(output_c_ratio) ? 24'h000001 : c_gap + 24'h000001;
      d_gap <= $rose(d_on) ? 24'h000001 : d_gap + 24'h000001;
      c_n <= reg_wr ? 2'h0 : c_n + {1'b0, $rose(output_c_ratio) && &c_n == 0};
      d_n <= reg_wr ? 2'h0 : d_n + {1'b0, $rose(d_on) && &d_n == 0};
    end
  end
  ////////////////////////////////////////
  unmapped_read_a: assert property ((reg_addr < 8'h86 || reg_addr > 8'h8B)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  c_read_a: assert property (reg_addr == 8'h86 && !reg_wr
    |=> reg_rdata == c_reg[23:16]) else $error("C byte read wrong");
  d_read_a: assert property (reg_addr == 8'h8B && !reg_wr
    |=> reg_rdata == d_reg[7:0]) else $error("D byte read wrong");
  c_period_a: assert property (c_reg[23:20] != 4'hF && c_n == 2'h3
    && c_reg > 24'h000001 && $rose(output_c_ratio) |-> c_gap == c_reg)
    else $error("C clock period wrong");
  d_space_a: assert property (fa && $rose(d_on)
    |-> d_gap == {6'h00, d_reg[15:0], 2'h0}) else $error("D spacing wrong");
  d_width_a: assert property (fa && $rose(d_on)
    |-> d_on[*4] ##1 !d_on) else $error("D pulse width wrong");
  // edge type follows a rising edge of a, centred type a falling edge
  d_align_a: assert property (fa && $rose(d_on)
    |-> $past(related_a, 2) == d_reg[19] && $past(related_a, 3) != d_reg[19])
    else $error("D pulse edge misaligned");
  c_self_a: assert property ((c_reg[23:20] == 4'hF
    && c_reg[17:16] == 2'h2)[*6] |-> output_c_ratio == c_reg[18])
    else $error("C self select not idle");
  d_self_a: assert property ((d_reg[23:20] == 4'hF
    && d_reg[17:16] == 2'h3)[*6] |-> output_d_ratio == d_reg[18])
    else $error("D self select not idle");
endmodule
bind synth_post_divider_frame_pulse div_checker u_chk (.mclk(mclk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .related_a(related_a),
  .related_b(related_b), .output_c_ratio(output_c_ratio),
  .output_d_ratio(output_d_ratio));

// *** tb/tb_top.sv ***
// self-checking bench for the output C/D post-dividers
`timescale 1ns/1ps
module tb_top;
  import synth_div_pkg::*;
  logic mclk, nrst, reg_wr, rel_a, rel_b, oc, od;
  reg_byte_t reg_addr, reg_wdata, reg_rdata;
  int err_count, check_count, cyc, hi, per, st;
  int ts[2];
  int rt[5] = '{6, 7, 8, 41, 64}; // even 8 beside odd 7
  int rp[3] = '{4, 6, 64};
  synth_post_divider_frame_pulse dut (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .related_a(rel_a), .related_b(rel_b),
    .output_c_ratio(oc), .output_d_ratio(od));
  sibling_divs sib (.mclk(mclk), .nrst(nrst), .related_a(rel_a),
    .related_b(rel_b));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // cycle count, also the hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge mclk);
    #5 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #5 reg_wr = 1'b0;
  endtask
  // low byte first so the mode byte lands last
  task automatic ww(input reg_byte_t b, input divider_word_t w);
    wr(b + 8'h02, w[7:0]);
    wr(b + 8'h01, w[15:8]);
    wr(b, w[23:16]);
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    @(posedge mclk);
    #5 reg_addr = a;
    @(posedge mclk);
    #1 chk(reg_rdata === e, "read");
  endtask
  function automatic logic o(input logic d);
    return d ? od : oc;
  endfunction
  // active length and start-to-start spacing of the next active phase
  task automatic meas(input logic d, input logic idle);
    repeat (9000) if (o(d) === idle) @(posedge mclk) #1;
    st = cyc;
    hi = 0;
    while (o(d) !== idle && hi < 9000) begin
      hi++;
      @(posedge mclk) #1;
    end
    per = hi;
    while (o(d) === idle && per < 9000) begin
      per++;
      @(posedge mclk) #1;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge mclk);
    #5 nrst = 1'b1;
    for (int a = 8'h84; a < 8'h8D; a++)
      rd(8'(a), (a == 8'h88 || a == 8'h8B) ? 8'h40 : 8'h00);
    // the first pass may start inside a high phase, so judge the second
    repeat (2) meas(1'b1, 1'b0);
    chk(per == 64 && hi == 32, "D default clock");
    // second reset, then ratios only rise so no restart waits a long wrap
    @(posedge mclk);
    #5 nrst = 1'b0;
    @(posedge mclk);
    #5 nrst = 1'b1;
    foreach (rt[i]) begin
      ww(8'h86, 24'(rt[i]));
      repeat (3) meas(1'b0, 1'b0);
      chk(per == rt[i] && hi == (per + 1) / 2, "clock");
      // only small odd ratios may leave the 45-55% band
      if (rt[i] % 2 == 0 || rt[i] >= 41)
        chk(hi * 20 >= per * 9 && hi * 20 <= per * 11, "duty");
    end
    ww(8'h89, 24'hEFFFFF);
    rd(8'h89, 8'hEF);
    rd(8'h8B, 8'hFF);
    // frame mode on D for selects A, B and C, every polarity and type
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 4; k++) begin
        ww(8'h89, {4'hF, 2'(k), 2'(s), 16'h0003});
        repeat (3) meas(1'b1, k[0]);
        chk(hi == rp[s] && per == 3 * rp[s], "frame");
        if (s == 0) ts[k / 2] = st;
      end
    chk((ts[1] - ts[0] + 400) % 4 == 2, "pulse type");
    // frame mode on C, timed by B with a two-period spacing
    ww(8'h86, 24'hF10002);
    repeat (3) meas(1'b0, 1'b0);
    chk(hi == 6 && per == 12, "C frame");
    ww(8'h86, 24'hF60003);
    ww(8'h89, 24'hF70003);
    repeat (9) @(posedge mclk);
    #1 chk(oc === 1'b1 && od === 1'b1, "self select");
    stop_test();
  end
endmodule
